// file: hw/secr_reporter.sv
// Notes on behaviour
// RL1 - NVM write timeout: emergency 5530, not saved, reportable.
// RL2 - Power-up unit verify fail: emergency 6140, saved, not reportable.
// RL3 - NVM checksum: emergency 6330, saved, reportable; recover via index 1011 restore.
// RL4 - Network hardware fault: emergency 7030, saved, not reportable.
// RL5 - NVM control data fault: status 0001, saved, reportable.
// RL6 - Illegal state transition request: status 0011, not saved.
// RL7 - Request to undefined state: status 0012, reportable, not saved.
// RL8 - Power-up verify fail also: status 0014, saved, reportable.
// RL9 - Bad mailbox configuration: status 0016, reportable, not saved.
// RL10 - Process-data watchdog expiry: status 001B, reportable, not saved.
// RL11 - Bad output config 001D, bad input config 001E, neither saved.
// RL12 - Bad watchdog configuration: status 001F, reportable, not saved.
// RL13 - Bad input PDO assignment 0024, bad output PDO assignment 0025.
// RL14 - SYNC0 lost in Operational: status 002C, encoder variants only.
// RL15 - No SYNC0 since distributed-clock entry: status 002D, reportable, not saved.
// RL16 - Status code shown in polled register; reportable emergencies sent as messages.
`timescale 1ns/100ps
`include "secr_regs.svh"
module secr_reporter #(
   parameter bit ENCODER_VARIANT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input secr_pkg::secr_fault_t fault_pls,
   input wire logic restore_done,
   output logic [15:0] al_status_ff,
   output logic al_err_ff,
   output secr_pkg::secr_rec_t emcy_msg_ff,
   output logic emcy_msg_vld_ff,
   output secr_pkg::secr_rec_t hist_rec_ff,
   output logic hist_wr_ff
);
   import secr_pkg::*;

   secr_rec_t al_rec;
   secr_rec_t em_rec;
   logic al_hit;
   logic em_hit;

   // Status code picks the lowest code among the faults this cycle
   always_comb begin
      al_rec = '{code: `SECR_AL_NONE, save: 1'b0, report: 1'b0};
      al_hit = 1'b1;
      if (fault_pls.nvm_ctrl) al_rec = '{`SECR_AL_NVM_CTRL, 1'b1, 1'b1}; // RL5
      else if (fault_pls.bad_trans) al_rec = '{`SECR_AL_BAD_TRANS, 1'b0, 1'b1}; // RL6
      else if (fault_pls.unk_state) al_rec = '{`SECR_AL_UNK_STATE, 1'b0, 1'b1}; // RL7
      else if (fault_pls.unit_verify) al_rec = '{`SECR_AL_VERIFY, 1'b1, 1'b1}; // RL8
      else if (fault_pls.mbx_cfg) al_rec = '{`SECR_AL_MBX_CFG, 1'b0, 1'b1}; // RL9
      else if (fault_pls.pd_wdt) al_rec = '{`SECR_AL_PD_WDT, 1'b0, 1'b1}; // RL10
      else if (fault_pls.rxpd_cfg) al_rec = '{`SECR_AL_RXPD_CFG, 1'b0, 1'b1}; // RL11
      else if (fault_pls.txpd_cfg) al_rec = '{`SECR_AL_TXPD_CFG, 1'b0, 1'b1}; // RL11
      else if (fault_pls.wdt_cfg) al_rec = '{`SECR_AL_WDT_CFG, 1'b0, 1'b1}; // RL12
      else if (fault_pls.txpdo_asg) al_rec = '{`SECR_AL_TXPDO_ASG, 1'b0, 1'b1}; // RL13
      else if (fault_pls.rxpdo_asg) al_rec = '{`SECR_AL_RXPDO_ASG, 1'b0, 1'b1}; // RL13
      else if (fault_pls.sync_lost && ENCODER_VARIANT)
         al_rec = '{`SECR_AL_SYNC_LOST, 1'b0, 1'b1}; // RL14
      else if (fault_pls.sync_none) al_rec = '{`SECR_AL_SYNC_NONE, 1'b0, 1'b1}; // RL15
      else al_hit = 1'b0;
   end

   // Emergency code, lowest code first
   always_comb begin
      em_rec = '{code: 16'h0000, save: 1'b0, report: 1'b0};
      em_hit = 1'b1;
      if (fault_pls.nvm_timeout) em_rec = '{`SECR_EMCY_NVM_TIMEOUT, 1'b0, 1'b1}; // RL1
      else if (fault_pls.unit_verify) em_rec = '{`SECR_EMCY_UNIT_VERIFY, 1'b1, 1'b0}; // RL2
      else if (fault_pls.nvm_csum) em_rec = '{`SECR_EMCY_NVM_CSUM, 1'b1, 1'b1}; // RL3
      else if (fault_pls.net_hw) em_rec = '{`SECR_EMCY_NET_HW, 1'b1, 1'b0}; // RL4
      else em_hit = 1'b0;
   end

   // Status register holds the last code; a completed restore clears it unless a status fault lands in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         al_status_ff <= `SECR_AL_NONE;
         al_err_ff <= 1'b0;
      end else if (al_hit) begin
         al_status_ff <= al_rec.code; // RL16
         al_err_ff <= 1'b1;
      end else if (restore_done) begin
         al_status_ff <= `SECR_AL_NONE; // RL3
         al_err_ff <= 1'b0;
      end
   end

   // Only reportable emergencies go out as a message
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         emcy_msg_ff <= '0;
         emcy_msg_vld_ff <= 1'b0;
      end else begin
         emcy_msg_vld_ff <= em_hit && em_rec.report; // RL16
         if (em_hit && em_rec.report) emcy_msg_ff <= em_rec;
      end
   end

   // History write; a saved emergency wins the slot over a saved status code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist_rec_ff <= '0;
         hist_wr_ff <= 1'b0;
      end else begin
         hist_wr_ff <= (em_hit && em_rec.save) || (al_hit && al_rec.save);
         if (em_hit && em_rec.save) hist_rec_ff <= em_rec; // RL2
         else if (al_hit && al_rec.save) hist_rec_ff <= al_rec; // RL5
      end
   end

   property p_timeout_msg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.nvm_timeout |=> emcy_msg_vld_ff && emcy_msg_ff.code == 16'h5530;
   endproperty
   a_timeout_msg: assert property (p_timeout_msg) else $error("timeout not reported"); // RL1

   property p_verify_nomsg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.unit_verify && !fault_pls.nvm_timeout |=> !emcy_msg_vld_ff && hist_wr_ff;
   endproperty
   a_verify_nomsg: assert property (p_verify_nomsg) else $error("verify handled wrong"); // RL2

   property p_nethw;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.net_hw && !fault_pls.nvm_timeout && !fault_pls.unit_verify
         && !fault_pls.nvm_csum |=> hist_wr_ff && hist_rec_ff.code == 16'h7030;
   endproperty
   a_nethw: assert property (p_nethw) else $error("net hw not saved"); // RL4

   property p_nvm_ctrl;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.nvm_ctrl |=> al_status_ff == 16'h0001 && al_err_ff;
   endproperty
   a_nvm_ctrl: assert property (p_nvm_ctrl) else $error("status 0001 missing"); // RL5

   property p_msg_reportable;
      @(posedge clk) disable iff (!rst_n)
         emcy_msg_vld_ff |-> emcy_msg_ff.report && emcy_msg_ff.code != 16'h6140;
   endproperty
   a_msg_reportable: assert property (p_msg_reportable) else $error("bad message"); // RL16

   property p_hist_saved;
      @(posedge clk) disable iff (!rst_n)
         hist_wr_ff |-> hist_rec_ff.save && hist_rec_ff.code != 16'h0011;
   endproperty
   a_hist_saved: assert property (p_hist_saved) else $error("unsaved code logged"); // RL6

   property p_status_hold;
      @(posedge clk) disable iff (!rst_n)
         !al_hit && !restore_done |=> $stable(al_status_ff);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status changed"); // RL16

   property p_sync_none;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.sync_none && $onehot(fault_pls) |=> al_status_ff == 16'h002d && !hist_wr_ff;
   endproperty
   a_sync_none: assert property (p_sync_none) else $error("status 002D missing"); // RL15

   // A lone timeout is reported but never kept in history
   property p_timeout_nosave;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.nvm_timeout && $onehot(fault_pls) |=> !hist_wr_ff;
   endproperty
   a_timeout_nosave: assert property (p_timeout_nosave) else $error("timeout logged"); // RL1

   property p_csum_saved;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.nvm_csum && !fault_pls.nvm_timeout && !fault_pls.unit_verify
         |=> emcy_msg_vld_ff && emcy_msg_ff.code == 16'h6330
         && hist_wr_ff && hist_rec_ff.code == 16'h6330;
   endproperty
   a_csum_saved: assert property (p_csum_saved) else $error("checksum mishandled"); // RL3

   // Restore with no status fault in the same cycle empties the register
   property p_restore_clear;
      @(posedge clk) disable iff (!rst_n)
         restore_done && !fault_pls.unit_verify && fault_pls[11:0] == 12'h000
         |=> al_status_ff == 16'h0000 && !al_err_ff;
   endproperty
   a_restore_clear: assert property (p_restore_clear) else $error("status kept"); // RL3

   property p_bad_trans;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.bad_trans && !fault_pls.nvm_ctrl |=> al_status_ff == 16'h0011 && al_err_ff;
   endproperty
   a_bad_trans: assert property (p_bad_trans) else $error("status 0011 missing"); // RL6

   property p_unk_state;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.unk_state && !fault_pls.nvm_ctrl && !fault_pls.bad_trans
         |=> al_status_ff == 16'h0012 && al_err_ff;
   endproperty
   a_unk_state: assert property (p_unk_state) else $error("status 0012 missing"); // RL7

   property p_verify_status;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.unit_verify && !fault_pls.nvm_ctrl && !fault_pls.bad_trans
         && !fault_pls.unk_state |=> al_status_ff == 16'h0014 && hist_wr_ff;
   endproperty
   a_verify_status: assert property (p_verify_status) else $error("status 0014 missing"); // RL8

   // Lone configuration and timing faults set their status and leave history alone
   property p_mbx_cfg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.mbx_cfg && $onehot(fault_pls) |=> al_status_ff == 16'h0016 && !hist_wr_ff;
   endproperty
   a_mbx_cfg: assert property (p_mbx_cfg) else $error("status 0016 missing"); // RL9

   property p_pd_wdt;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.pd_wdt && $onehot(fault_pls) |=> al_status_ff == 16'h001b && !hist_wr_ff;
   endproperty
   a_pd_wdt: assert property (p_pd_wdt) else $error("status 001B missing"); // RL10

   property p_rxpd_cfg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.rxpd_cfg && $onehot(fault_pls) |=> al_status_ff == 16'h001d && !hist_wr_ff;
   endproperty
   a_rxpd_cfg: assert property (p_rxpd_cfg) else $error("status 001D missing"); // RL11

   property p_txpd_cfg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.txpd_cfg && $onehot(fault_pls) |=> al_status_ff == 16'h001e && !hist_wr_ff;
   endproperty
   a_txpd_cfg: assert property (p_txpd_cfg) else $error("status 001E missing"); // RL11

   property p_wdt_cfg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.wdt_cfg && $onehot(fault_pls) |=> al_status_ff == 16'h001f && !hist_wr_ff;
   endproperty
   a_wdt_cfg: assert property (p_wdt_cfg) else $error("status 001F missing"); // RL12

   property p_txpdo_asg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.txpdo_asg && $onehot(fault_pls) |=> al_status_ff == 16'h0024 && !hist_wr_ff;
   endproperty
   a_txpdo_asg: assert property (p_txpdo_asg) else $error("status 0024 missing"); // RL13

   property p_rxpdo_asg;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.rxpdo_asg && $onehot(fault_pls) |=> al_status_ff == 16'h0025 && !hist_wr_ff;
   endproperty
   a_rxpdo_asg: assert property (p_rxpdo_asg) else $error("status 0025 missing"); // RL13

   property p_sync_lost;
      @(posedge clk) disable iff (!rst_n)
         fault_pls.sync_lost && $onehot(fault_pls) && ENCODER_VARIANT
         |=> al_status_ff == 16'h002c && !hist_wr_ff;
   endproperty
   a_sync_lost: assert property (p_sync_lost) else $error("status 002C missing"); // RL14
endmodule

// file: hw/secr_regs.svh
`ifndef SECR_REGS_SVH
`define SECR_REGS_SVH
// Emergency error codes
`define SECR_EMCY_NVM_TIMEOUT 16'h5530
`define SECR_EMCY_UNIT_VERIFY 16'h6140
`define SECR_EMCY_NVM_CSUM 16'h6330
`define SECR_EMCY_NET_HW 16'h7030
// Application-layer status codes
`define SECR_AL_NONE 16'h0000
`define SECR_AL_NVM_CTRL 16'h0001
`define SECR_AL_BAD_TRANS 16'h0011
`define SECR_AL_UNK_STATE 16'h0012
`define SECR_AL_VERIFY 16'h0014
`define SECR_AL_MBX_CFG 16'h0016
`define SECR_AL_PD_WDT 16'h001b
`define SECR_AL_RXPD_CFG 16'h001d
`define SECR_AL_TXPD_CFG 16'h001e
`define SECR_AL_WDT_CFG 16'h001f
`define SECR_AL_TXPDO_ASG 16'h0024
`define SECR_AL_RXPDO_ASG 16'h0025
`define SECR_AL_SYNC_LOST 16'h002c
`define SECR_AL_SYNC_NONE 16'h002d
// Restore-defaults object index
`define SECR_RESTORE_INDEX 16'h1011
`endif

// file: hw/secr_pkg.sv
package secr_pkg;
   // One coded event: code, keep in history, may be reported
   typedef struct packed {
      logic [15:0] code;
      logic save;
      logic report;
   } secr_rec_t;
   // Fault detector inputs
   typedef struct packed {
      logic nvm_timeout;
      logic unit_verify;
      logic nvm_csum;
      logic net_hw;
      logic nvm_ctrl;
      logic bad_trans;
      logic unk_state;
      logic mbx_cfg;
      logic pd_wdt;
      logic rxpd_cfg;
      logic txpd_cfg;
      logic wdt_cfg;
      logic txpdo_asg;
      logic rxpdo_asg;
      logic sync_lost;
      logic sync_none;
   } secr_fault_t;
endpackage

// file: test/secr_master_model.sv
`timescale 1ns/100ps
`include "secr_regs.svh"
module secr_master_model (
   input wire logic clk,
   input wire logic rst_n,
   input secr_pkg::secr_rec_t emcy_msg_ff,
   input wire logic emcy_msg_vld_ff,
   output logic restore_done,
   output logic [7:0] n_logged
);
   import secr_pkg::*;
   // Checksum emergency read: restore defaults at once, no slower recovery modelled
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) restore_done <= 1'b0;
      else restore_done <= emcy_msg_vld_ff && emcy_msg_ff.code == `SECR_EMCY_NVM_CSUM;
   end
   // Log every reportable emergency message that is read
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) n_logged <= 8'h00;
      else if (emcy_msg_vld_ff && emcy_msg_ff.report) n_logged <= n_logged + 8'h01;
   end
endmodule

// file: test/tb_secr_reporter.sv
`timescale 1ns/100ps
module tb_secr_reporter;
   import secr_pkg::*;
   localparam logic [15:0] EMC [0:3] = '{16'h5530, 16'h6140, 16'h6330, 16'h7030};
   localparam logic [15:0] STC [0:15] = '{16'h0000, 16'h0014, 16'h0000, 16'h0000,
      16'h0001, 16'h0011, 16'h0012, 16'h0016, 16'h001b, 16'h001d, 16'h001e,
      16'h001f, 16'h0024, 16'h0025, 16'h002c, 16'h002d};
   localparam logic [0:15] ST_SAVE = 16'h4800;
   localparam logic [0:3] EM_SAVE = 4'h7;
   localparam logic [0:3] EM_REP = 4'ha;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   secr_fault_t fault_pls = '0;
   logic restore_done;
   logic [15:0] al_status_ff;
   logic al_err_ff, emcy_msg_vld_ff, hist_wr_ff;
   secr_rec_t emcy_msg_ff, hist_rec_ff;
   secr_rec_t x_em = '0;
   secr_rec_t x_hs = '0;
   logic [15:0] x_st = 16'h0000;
   logic [15:0] lfsr = 16'h0016;
   logic [7:0] n_logged;
   int errors = 0;
   int n_checks = 0;
   int n_rep = 0;
   // Free-running bench clock
   always #12.5 clk = ~clk;
   secr_reporter secr_reporter_i (.clk(clk), .rst_n(rst_n), .fault_pls(fault_pls),
      .restore_done(restore_done), .al_status_ff(al_status_ff), .al_err_ff(al_err_ff),
      .emcy_msg_ff(emcy_msg_ff), .emcy_msg_vld_ff(emcy_msg_vld_ff),
      .hist_rec_ff(hist_rec_ff), .hist_wr_ff(hist_wr_ff));
   secr_master_model secr_master_model_i (.clk(clk), .rst_n(rst_n),
      .emcy_msg_ff(emcy_msg_ff), .emcy_msg_vld_ff(emcy_msg_vld_ff),
      .restore_done(restore_done), .n_logged(n_logged));
   function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Emergency for a fault vector: the lowest code wins
   function automatic secr_rec_t exp_em(input logic [15:0] v);
      secr_rec_t r;
      r = '0;
      for (int i = 3; i >= 0; i--) begin
         if (v[15-i]) r = '{EMC[i], EM_SAVE[i], EM_REP[i]};
      end
      return r;
   endfunction
   // Status for a fault vector: the lowest code wins; sync loss counts on encoder units
   function automatic secr_rec_t exp_st(input logic [15:0] v);
      secr_rec_t r;
      r = '0;
      for (int i = 15; i >= 1; i--) begin
         if (v[15-i] && STC[i] != 16'h0000 && (!r.report || STC[i] < r.code))
            r = '{STC[i], ST_SAVE[i], 1'b1};
      end
      return r;
   endfunction
   // Check the previous vector's answer, then drive the next one back to back
   task automatic step(input logic [15:0] v);
      secr_rec_t sr;
      logic rp;
      @(negedge clk);
      chk("status", {2'b00, al_status_ff}, {2'b00, x_st});
      chk("status", {2'b00, al_status_ff}, {2'b00, x_st});
      chk("err flag", {17'h0, al_err_ff}, {17'h0, x_st != 16'h0000});
      chk("emcy strobe", {17'h0, emcy_msg_vld_ff}, {17'h0, x_em.report});
      if (x_em.report) chk("emcy", emcy_msg_ff, x_em);
      chk("hist strobe", {17'h0, hist_wr_ff}, {17'h0, x_hs.save});
      if (x_hs.save) chk("hist", hist_rec_ff, x_hs);
      // A checksum message standing now makes the master restore during the next vector
      rp = x_em.report && x_em.code == 16'h6330;
      fault_pls = v;
      x_em = exp_em(v);
      sr = exp_st(v);
      x_hs = x_em.save ? x_em : sr;
      if (sr.report) x_st = sr.code; // A fault in the restore cycle wins
      else if (rp) x_st = 16'h0000;
      if (x_em.report) n_rep++;
   endtask
   // Watchdog sized well above the planned run
   initial begin
      #(25 * 400);
      errors++;
      conclude();
   end
   // Singles, corner vectors, then sparse random bursts
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 16; i++) step(16'h8000 >> i);
      step(16'hffff);
      step(16'h4001);
      repeat (200) begin
         lfsr = nxt_lfsr(lfsr);
         step(lfsr & {lfsr[2:0], lfsr[15:3]});
      end
      step(16'h0000);
      step(16'h0000); // The master counts a message one edge after it appears
      chk("logged", {10'h0, n_logged}, {10'h0, n_rep[7:0]});
      conclude();
   end
endmodule
